/* design/kpm_keypad_math.sv */
// Keypad parameter editing, access control and channel arithmetic
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module kpm_keypad_math
    import kpm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Front keys, debounced levels
    input wire logic key_prog,
    input wire logic key_up,
    input wire logic key_down,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Converter samples
    input wire logic adc_valid,
    input wire logic [31:0] adc_data,
    output logic meas_ch,
    // Display and results
    output kpm_disp_t disp,
    output logic [31:0] ch1_value,
    output logic [31:0] ch2_value,
    output logic [31:0] arith_value,
    output logic [31:0] disp_value,
    // Nonvolatile write port
    output kpm_nv_t nv
);
    localparam kpm_state_t RST = kpm_reset_state();

    kpm_state_t r_reg;
    kpm_state_t r_next;

    function automatic logic [3:0] eff_level(input logic [31:0] lvl,
                                             input logic [31:0] lock,
                                             input logic [31:0] auth);
        logic [3:0] l;
        l = (lvl > 32'(LVL_MAX)) ? 4'(LVL_MAX) : lvl[3:0];
        if (lock == auth) begin
            l = 4'h0;
        end
        return {l[3:1], 1'b0};
    endfunction

    function automatic logic allowed(input logic [7:0] i, input logic [3:0] l);
        logic ok;
        ok = 1'b0;
        if (i == 8'(IDX_BRIGHT) || i == 8'(IDX_LOCK) || i == 8'(IDX_SERIAL)) begin
            ok = 1'b1;
        end else if (i >= 8'(IDX_SETP_LO) && i <= 8'(IDX_SETP_HI)) begin
            ok = (l <= 4'(LVL_SETP));
        end else if (i == 8'(IDX_IFACE) ||
                     (i >= 8'(IDX_AOUT_LO) && i <= 8'(IDX_AOUT_HI))) begin
            ok = (l <= 4'(LVL_IFACE));
        end else if (i <= 8'(IDX_MEAS_HI)) begin
            ok = (l <= 4'(LVL_MEAS));
        end else begin
            ok = (l == 4'h0);
        end
        return ok;
    endfunction

    // Wraps inside the stored range; returns start when nothing is open
    function automatic logic [7:0] step_idx(input logic [7:0] start,
                                            input logic up,
                                            input logic [3:0] l);
        logic [7:0] c;
        logic [7:0] res;
        logic found;
        res = start;
        found = 1'b0;
        c = start;
        for (int k = 0; k < PARAM_DEPTH; k++) begin
            c = up ? ((c == 8'(PARAM_DEPTH - 1)) ? 8'h00 : c + 8'h01)
                   : ((c == 8'h00) ? 8'(PARAM_DEPTH - 1) : c - 8'h01);
            if (!found && allowed(c, l)) begin
                res = c;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // Editing works on the magnitude; the sign is not editable from keys
    function automatic logic [DIGITS-1:0][3:0] to_bcd(input logic [31:0] v);
        logic [DIGITS-1:0][3:0] d;
        logic [31:0] m;
        m = v[31] ? (32'h0 - v) : v;
        for (int k = 0; k < DIGITS; k++) begin
            d[k] = 4'(m % 32'd10);
            m = m / 32'd10;
        end
        return d;
    endfunction

    function automatic logic [31:0] from_bcd(input logic [DIGITS-1:0][3:0] d);
        logic [31:0] v;
        v = 32'h0;
        for (int k = DIGITS - 1; k >= 0; k--) begin
            v = v * 32'd10 + 32'(d[k]);
        end
        return v;
    endfunction

    function automatic logic value_ok(input logic [7:0] i, input logic [31:0] v,
                                      input logic single);
        logic ok;
        ok = 1'b1;
        if (i == 8'(IDX_ARITH)) begin
            ok = (v >= 32'(AR_CH1) && v <= 32'(AR_PCT));
        end else if (i == 8'(IDX_CFG1) || i == 8'(IDX_CFG2)) begin
            ok = (v <= 32'(CFG_MAX));
        end else if (i == 8'(IDX_MTIME)) begin
            ok = (v <= 32'(MT_MAX)) &&
                 (v >= (single ? 32'(MT_MIN_ONE) : 32'(MT_MIN_TWO)));
        end else if (i == 8'(IDX_ULEVEL)) begin
            ok = (v <= 32'(LVL_MAX));
        end else if (i == 8'(IDX_DP1) || i == 8'(IDX_DP2) ||
                     i == 8'(IDX_CONST_DP) || i == 8'(IDX_CALC_DP)) begin
            ok = (v <= 32'(DP_MAX));
        end
        return ok;
    endfunction

    // Factor taking a value with dp decimals to units of 1e-4
    function automatic logic signed [95:0] scale_e4(input logic [31:0] dp);
        logic signed [95:0] f;
        case (dp)
            32'd0: f = 96'sd10000;
            32'd1: f = 96'sd1000;
            32'd2: f = 96'sd100;
            32'd3: f = 96'sd10;
            default: f = 96'sd1;
        endcase
        return f;
    endfunction

    function automatic logic signed [63:0] chan_scale(input logic [31:0] raw,
                                                      input logic [31:0] cfg,
                                                      input logic [31:0] full,
                                                      input logic [31:0] off,
                                                      input logic [31:0] shift);
        logic signed [63:0] z;
        logic signed [63:0] f;
        logic signed [63:0] num;
        logic [1:0] c;
        c = (cfg > 32'(CFG_MAX)) ? 2'(CFG_SENSOR) : cfg[1:0];
        z = 64'(CAL_RAW_ZERO[c]);
        f = 64'(CAL_RAW_FULL[c]);
        num = (64'($signed(raw)) - z) * (64'($signed(full)) - 64'($signed(off)));
        return 64'($signed(off)) + num / (f - z)
               + 64'($signed(shift));
    endfunction

    logic [3:0] lvl;
    logic tick;
    logic prog_rise;
    logic prog_fall;
    logic up_rise;
    logic dn_rise;
    logic hold_hit;
    logic single;
    logic [13:0] period;
    logic [31:0] edit_val;
    logic signed [95:0] a;
    logic signed [95:0] b;
    logic signed [95:0] k;
    logic signed [95:0] res;

    always_comb begin
        r_next = r_reg;
        r_next.nv.we = 1'b0;
        lvl = eff_level(r_reg.mem[IDX_ULEVEL], r_reg.mem[IDX_LOCK],
                        r_reg.mem[IDX_AUTH]);
        tick = (r_reg.tick_cnt == 16'(TICK_CYC - 1));
        r_next.tick_cnt = tick ? 16'h0 : r_reg.tick_cnt + 16'h1;
        prog_rise = key_prog & ~r_reg.prog_q;
        prog_fall = ~key_prog & r_reg.prog_q;
        up_rise = key_up & ~r_reg.up_q;
        dn_rise = key_down & ~r_reg.dn_q;
        r_next.prog_q = key_prog;
        r_next.up_q = key_up;
        r_next.dn_q = key_down;
        single = (r_reg.mem[IDX_ARITH] == 32'(AR_CH1)) ||
                 (r_reg.mem[IDX_ARITH] == 32'(AR_CH2));
        edit_val = from_bcd(r_reg.dig);
        // Hold timer restarts on each program press
        hold_hit = key_prog && !r_reg.held && r_reg.hold_ms == 10'(HOLD_MS);
        if (!key_prog) begin
            r_next.hold_ms = 10'h0;
            r_next.held = 1'b0;
        end else if (tick && r_reg.hold_ms != 10'(HOLD_MS)) begin
            r_next.hold_ms = r_reg.hold_ms + 10'h1;
        end
        if (hold_hit) begin
            r_next.held = 1'b1;
        end
        if (key_prog || key_up || key_down || r_reg.st == ST_OPER) begin
            r_next.idle_ms = 13'h0;
        end else if (tick) begin
            r_next.idle_ms = r_reg.idle_ms + 13'h1;
        end
        if (tick && r_reg.bars_ms != 10'h0) begin
            r_next.bars_ms = r_reg.bars_ms - 10'h1;
        end
        case (r_reg.st)
            ST_OPER: begin
                if (prog_rise) begin
                    r_next.st = ST_SELECT;
                    r_next.idx = step_idx(8'(PARAM_DEPTH - 1), 1'b1, lvl);
                end
            end
            ST_SELECT: begin
                if (key_prog && up_rise) begin
                    r_next.idx = step_idx(r_reg.idx, 1'b1, lvl);
                end else if (key_prog && dn_rise) begin
                    r_next.idx = step_idx(r_reg.idx, 1'b0, lvl);
                end else if (!key_prog && (up_rise || dn_rise)) begin
                    r_next.st = ST_EDIT;
                    r_next.dig = to_bcd(r_reg.mem[r_reg.idx[5:0]]);
                    r_next.cur = 3'h0;
                end
            end
            ST_EDIT: begin
                if (up_rise) begin
                    r_next.dig[r_reg.cur] = (r_reg.dig[r_reg.cur] == 4'h9) ?
                        4'h0 : r_reg.dig[r_reg.cur] + 4'h1;
                end else if (dn_rise) begin
                    r_next.dig[r_reg.cur] = (r_reg.dig[r_reg.cur] == 4'h0) ?
                        4'h9 : r_reg.dig[r_reg.cur] - 4'h1;
                end
                if (prog_fall && !r_reg.held) begin
                    r_next.cur = (r_reg.cur == 3'(DIGITS - 1)) ?
                        3'h0 : r_reg.cur + 3'h1;
                end
                if (hold_hit) begin
                    r_next.st = ST_SELECT;
                    if (allowed(r_reg.idx, lvl) &&
                        value_ok(r_reg.idx, edit_val, single)) begin
                        r_next.mem[r_reg.idx[5:0]] = edit_val;
                        r_next.nv.we = 1'b1;
                        r_next.nv.addr = r_reg.idx;
                        r_next.nv.data = edit_val;
                        r_next.bars_ms = 10'(BARS_MS);
                    end
                end
            end
            default: begin
                r_next.st = ST_OPER;
            end
        endcase
        if (r_reg.st != ST_OPER && r_reg.idle_ms == 13'(IDLE_MS)) begin
            r_next.st = ST_OPER;
        end
        // Software writes bypass the key lock and are not saved to store
        if (reg_wr && reg_addr[7:6] == 2'b00) begin
            r_next.mem[reg_addr[5:0]] = reg_wdata;
        end
        r_next.rdata = 32'h0;
        if (reg_rd) begin
            if (reg_addr[7:6] == 2'b00) begin
                r_next.rdata = r_reg.mem[reg_addr[5:0]];
            end else if (reg_addr == REG_STATUS) begin
                r_next.rdata = {16'h0, r_reg.idx, 1'b0, r_reg.st, lvl};
            end else if (reg_addr == REG_ARITH) begin
                r_next.rdata = r_reg.arith;
            end else if (reg_addr == REG_CH1) begin
                r_next.rdata = r_reg.ch1;
            end else if (reg_addr == REG_CH2) begin
                r_next.rdata = r_reg.ch2;
            end
        end
        // Measuring cycle, time setting in 10 ms steps
        // Product kept at 14 bits so the 10 s maximum does not wrap
        period = r_reg.mem[IDX_MTIME][13:0] * 14'd10;
        if (tick) begin
            r_next.meas_ms = (r_reg.meas_ms >= period - 14'h1) ?
                14'h0 : r_reg.meas_ms + 14'h1;
        end
        if (single) begin
            r_next.meas_ch = (r_reg.mem[IDX_ARITH] == 32'(AR_CH2));
        end else begin
            r_next.meas_ch = (r_next.meas_ms >= {1'b0, period[13:1]});
        end
        if (adc_valid) begin
            r_next.raw[r_reg.meas_ch] = adc_data;
        end
        a = 96'(chan_scale(r_reg.raw[0], r_reg.mem[IDX_CFG1], r_reg.mem[IDX_FULL1],
                           r_reg.mem[IDX_OFF1], r_reg.mem[IDX_SHIFT1]));
        b = 96'(chan_scale(r_reg.raw[1], r_reg.mem[IDX_CFG2], r_reg.mem[IDX_FULL2],
                           r_reg.mem[IDX_OFF2], r_reg.mem[IDX_SHIFT2]));
        k = 96'($signed(r_reg.mem[IDX_CONST])) * scale_e4(r_reg.mem[IDX_CONST_DP]);
        a = a * scale_e4(r_reg.mem[IDX_DP1]);
        b = b * scale_e4(r_reg.mem[IDX_DP2]);
        // Division by a zero channel yields zero rather than a trap
        case (r_reg.mem[IDX_ARITH])
            32'(AR_SUM): res = (a + b) * k / 96'sd10000;
            32'(AR_DIFF): res = (a - b) * k / 96'sd10000;
            32'(AR_PROD): res = a * b / 96'sd10000 * k / 96'sd10000;
            32'(AR_RATIO): res = (b == 96'sd0) ? 96'sd0 : a * k / b;
            32'(AR_PCT): res = (b == 96'sd0) ? 96'sd0 :
                a * 96'sd100 * 96'sd10000 / b;
            default: res = 96'sd0;
        endcase
        res = res / scale_e4(r_reg.mem[IDX_CALC_DP]);
        if (tick && r_reg.meas_ms >= period - 14'h1) begin
            r_next.ch1 = (single && r_reg.mem[IDX_ARITH] == 32'(AR_CH2)) ?
                32'h0 : 32'(a / scale_e4(r_reg.mem[IDX_DP1]));
            r_next.ch2 = (single && r_reg.mem[IDX_ARITH] == 32'(AR_CH1)) ?
                32'h0 : 32'(b / scale_e4(r_reg.mem[IDX_DP2]));
            r_next.arith = single ? 32'h0 : res[31:0];
            r_next.disp = single ? ((r_reg.mem[IDX_ARITH] == 32'(AR_CH1)) ?
                32'(a / scale_e4(r_reg.mem[IDX_DP1])) :
                32'(b / scale_e4(r_reg.mem[IDX_DP2]))) : res[31:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign meas_ch = r_reg.meas_ch;
    assign ch1_value = r_reg.ch1;
    assign ch2_value = r_reg.ch2;
    assign arith_value = r_reg.arith;
    assign disp_value = r_reg.disp;
    assign nv = r_reg.nv;
    assign disp.prog_mode = (r_reg.st != ST_OPER);
    assign disp.editing = (r_reg.st == ST_EDIT);
    assign disp.bars = (r_reg.bars_ms != 10'h0);
    assign disp.index = r_reg.idx;
    assign disp.digits = r_reg.dig;
    assign disp.cursor = r_reg.cur;
endmodule
`default_nettype wire

/* design/kpm_pkg.sv */
// Constants, codes and carrier types for the keypad parameter block
package kpm_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_MS = 1000;
    localparam int IDLE_MS = 7000;
    localparam int BARS_MS = 1000;
    localparam int PARAM_DEPTH = 64;
    localparam int DIGITS = 6;
    localparam int E4 = 10000;
    // Parameter indices
    localparam int IDX_CFG1 = 0, IDX_FULL1 = 1, IDX_OFF1 = 2, IDX_DP1 = 3;
    localparam int IDX_SHIFT1 = 4, IDX_CFG2 = 5, IDX_FULL2 = 6, IDX_OFF2 = 7;
    localparam int IDX_DP2 = 8, IDX_SHIFT2 = 9, IDX_MTIME = 14, IDX_ARITH = 15;
    localparam int IDX_CONST = 16, IDX_CONST_DP = 17, IDX_CALC_DP = 18;
    localparam int IDX_BRIGHT = 19, IDX_AOUT_LO = 20, IDX_AOUT_HI = 22;
    localparam int IDX_IFACE = 34, IDX_LOCK = 50, IDX_AUTH = 51;
    localparam int IDX_ULEVEL = 52, IDX_SETP_LO = 59, IDX_SETP_HI = 95;
    localparam int IDX_MEAS_HI = 18, IDX_SERIAL = 200;
    localparam int LVL_SETP = 6, LVL_IFACE = 4, LVL_MEAS = 2, LVL_MAX = 8;
    // Arithmetic select and input configuration codes
    localparam int AR_CH1 = 1, AR_CH2 = 2, AR_SUM = 3, AR_DIFF = 4;
    localparam int AR_PROD = 5, AR_RATIO = 6, AR_PCT = 7, AR_DEF = 3;
    localparam int CFG_SENSOR = 0, CFG_MAX = 3, DP_MAX = 4;
    // Measuring time in 10 ms units
    localparam int MT_MIN_TWO = 20, MT_MIN_ONE = 10, MT_MAX = 1000;
    localparam int MT_DEF = 20, FULL_DEF = 10000, BRIGHT_DEF = 3;
    localparam int CONST_DEF = 1;
    // Stored converter counts at zero and full scale per range
    localparam int CAL_RAW_ZERO [4] = '{0, 0, 0, 1677722};
    localparam int CAL_RAW_FULL [4] = '{8388607, 8388607, 8388607, 8388607};
    // Register port map; parameters sit at 0x00..0x3f
    localparam logic [7:0] REG_STATUS = 8'h40;
    localparam logic [7:0] REG_ARITH = 8'h41;
    localparam logic [7:0] REG_CH1 = 8'h42;
    localparam logic [7:0] REG_CH2 = 8'h43;

    typedef enum logic [2:0] {
        ST_OPER = 3'b001,
        ST_SELECT = 3'b010,
        ST_EDIT = 3'b100
    } kpm_st_t;

    typedef struct packed {
        logic prog_mode;
        logic editing;
        logic bars;
        logic [7:0] index;
        logic [DIGITS-1:0][3:0] digits;
        logic [2:0] cursor;
    } kpm_disp_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [31:0] data;
    } kpm_nv_t;

    typedef struct packed {
        kpm_st_t st;
        logic [7:0] idx;
        logic [PARAM_DEPTH-1:0][31:0] mem;
        logic [DIGITS-1:0][3:0] dig;
        logic [2:0] cur;
        logic [15:0] tick_cnt;
        logic [9:0] hold_ms;
        logic held;
        logic [12:0] idle_ms;
        logic [9:0] bars_ms;
        logic prog_q;
        logic up_q;
        logic dn_q;
        logic [13:0] meas_ms;
        logic meas_ch;
        logic [1:0][31:0] raw;
        logic [31:0] ch1;
        logic [31:0] ch2;
        logic [31:0] arith;
        logic [31:0] disp;
        kpm_nv_t nv;
        logic [31:0] rdata;
    } kpm_state_t;

    function automatic kpm_state_t kpm_reset_state();
        kpm_state_t s;
        s = '0;
        s.st = ST_OPER;
        s.mem[IDX_FULL1] = 32'(FULL_DEF);
        s.mem[IDX_FULL2] = 32'(FULL_DEF);
        s.mem[IDX_MTIME] = 32'(MT_DEF);
        s.mem[IDX_ARITH] = 32'(AR_DEF);
        s.mem[IDX_CONST] = 32'(CONST_DEF);
        s.mem[IDX_BRIGHT] = 32'(BRIGHT_DEF);
        return s;
    endfunction
endpackage

/* sim/kpm_keypad_math_chk.sv */
// Port checker for the keypad parameter block
`timescale 1ns/100ps
`default_nettype none
module kpm_keypad_math_chk
    import kpm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic key_prog,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire kpm_disp_t disp,
    input wire kpm_nv_t nv
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] idle_cnt;
    logic [31:0] run_cnt;
    logic prog_q;
    logic any_key;
    assign any_key = key_prog | key_up | key_down;
    // Length of the latest program-key press is kept after release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= '0;
            run_cnt <= '0;
            prog_q <= 1'b0;
        end else begin
            idle_cnt <= (!disp.prog_mode || any_key) ? '0 : idle_cnt + 1;
            prog_q <= key_prog;
            if (key_prog) begin
                run_cnt <= prog_q ? run_cnt + 1 : 32'd1;
            end
        end
    end
    sequence top_digit_s;
        disp.editing && disp.cursor == 3'd5;
    endsequence
    sequence cursor_moved_s;
        disp.editing && $changed(disp.cursor);
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its slot");
    nv_pulse_a: assert property (nv.we |=> !nv.we)
        else $error("store write longer than one cycle");
    save_bars_a: assert property (nv.we |-> disp.bars && !disp.editing)
        else $error("save without bars");
    bars_cause_a: assert property ($rose(disp.bars) |-> nv.we)
        else $error("bars without a save");
    hold_save_a: assert property (
        nv.we |-> run_cnt >= (HOLD_MS - 1) * TICK_CYC)
        else $error("save before a full hold");
    idle_exit_a: assert property (
        idle_cnt < (IDLE_MS + 2) * TICK_CYC)
        else $error("programming mode outlived the idle time");
    cursor_wrap_a: assert property (
        top_digit_s ##1 cursor_moved_s |-> disp.cursor == 3'd0)
        else $error("cursor did not wrap to lowest digit");
    cursor_step_a: assert property (
        (disp.editing && disp.cursor != 3'd5) ##1 cursor_moved_s
        |-> disp.cursor == $past(disp.cursor) + 3'd1)
        else $error("cursor skipped a digit");
endmodule
bind kpm_keypad_math kpm_keypad_math_chk #(.TICK_CYC(TICK_CYC)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .key_prog(key_prog),
    .key_up(key_up), .key_down(key_down), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .disp(disp), .nv(nv));
`default_nettype wire

/* sim/kpm_operator.sv */
// Operator model pressing the three front keys
`timescale 1ns/100ps
`default_nettype none
module kpm_operator #(
    parameter int TICK_CYC = 4
) (
    input wire logic core_clk,
    output logic key_prog,
    output logic key_up,
    output logic key_down
);
    initial begin
        key_prog = 1'b0;
        key_up = 1'b0;
        key_down = 1'b0;
    end
    // Key 0 program, 1 up, 2 down; a long tap is the one-second hold
    task automatic tap(input int k, input int ticks);
        @(posedge core_clk);
        case (k)
            0: key_prog <= 1'b1;
            1: key_up <= 1'b1;
            default: key_down <= 1'b1;
        endcase
        repeat (ticks * TICK_CYC) @(posedge core_clk);
        {key_prog, key_up, key_down} <= 3'b000;
        // Gap keeps two presses from merging into one edge
        repeat (4 * TICK_CYC) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the keypad parameter block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import kpm_pkg::*;
    localparam int TK = 4;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic key_prog, key_up, key_down, meas_ch;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic adc_valid = 1'b0;
    logic [31:0] adc_data = 32'h007f_ffff;
    logic [31:0] reg_rdata, ch1_value, ch2_value, arith_value, disp_value;
    kpm_disp_t disp;
    kpm_nv_t nv;
    int bad_count = 0;
    int tests_run = 0;
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) adc_valid <= ~adc_valid;
    kpm_keypad_math #(.TICK_CYC(TK)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .key_prog(key_prog), .key_up(key_up), .key_down(key_down),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
        .adc_data(adc_data), .meas_ch(meas_ch), .disp(disp),
        .ch1_value(ch1_value), .ch2_value(ch2_value),
        .arith_value(arith_value), .disp_value(disp_value), .nv(nv));
    kpm_operator #(.TICK_CYC(TK)) op (.core_clk(core_clk),
        .key_prog(key_prog), .key_up(key_up), .key_down(key_down));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata, exp);
    endtask
    task automatic hold_save(input logic exp_we, input logic [31:0] d);
        logic seen;
        seen = 1'b0;
        fork
            op.tap(0, 1003);
            repeat (1010 * TK) begin
                @(negedge core_clk);
                if (nv.we === 1'b1 && !seen) begin
                    seen = 1'b1;
                    check({24'h0, nv.addr}, 32'h0);
                    check(nv.data, d);
                end
            end
        join
        check(32'(seen), 32'(exp_we));
        check(32'(disp.bars), 32'(exp_we));
    endtask
    task automatic idle_out();
        int n;
        n = 0;
        while (disp.prog_mode === 1'b1 && n < 7100 * TK) begin
            @(negedge core_clk);
            n++;
        end
        check(32'(n > 6990 * TK), 32'h1);
        if (disp.prog_mode !== 1'b0) begin
            bad_count++;
            end_sim();
        end
    endtask
    task automatic arith_scn();
        logic [7:0] pa [8] = '{8'h00, 8'h05, 8'h01, 8'h03, 8'h06, 8'h08,
            8'h10, 8'h12};
        int pv [8] = '{1, 1, 1000, 1, 4000, 2, 20, 1};
        int ea [7] = '{0, 0, 28000, 12000, 800000, 500, 2500};
        for (int i = 0; i < 8; i++)
            wr(pa[i], pv[i]);
        for (int m = 1; m <= 7; m++) begin
            wr(8'h0f, m);
            repeat (1700) @(posedge core_clk);
            check(arith_value, ea[m-1]);
            check(ch1_value, (m == 2) ? 0 : 1000);
            check(ch2_value, (m == 1) ? 0 : 4000);
            check(disp_value, (m == 1) ? 1000 : (m == 2) ? 4000 : ea[m-1]);
            rd(8'h41, ea[m-1]);
            if (m < 3)
                check(32'(meas_ch), m - 1);
        end
        wr(8'h04, 5);
        wr(8'h00, 3);
        adc_data <= 32'd1677722;
        repeat (1700) @(posedge core_clk);
        check(ch1_value, 5);
        wr(8'h42, 32'h0000_0077);
        rd(8'h42, 32'h0000_0005);
    endtask
    task automatic edit_scn();
        op.tap(0, 3);
        check(32'(disp.index), 32'h0);
        op.tap(1, 3);
        op.tap(1, 3);
        check(32'(disp.digits[0]), 32'h4);
        hold_save(1'b0, 32'h0);
        op.tap(2, 3);
        op.tap(2, 3);
        check(32'(disp.digits[0]), 32'h2);
        for (int i = 1; i <= 6; i++) begin
            op.tap(0, 3);
            check(32'(disp.cursor), 32'(i % 6));
        end
        hold_save(1'b1, 32'h2);
        rd(8'h00, 32'h2);
        idle_out();
    endtask
    task automatic level_scn();
        wr(8'h34, 5);
        wr(8'h33, 32'd1234);
        op.tap(0, 3);
        check(32'(disp.index), 32'd19);
        rd(8'h40, 32'h0000_1324);
        idle_out();
        wr(8'h32, 32'd1234);
        op.tap(0, 3);
        check(32'(disp.index), 32'h0);
        rd(8'h40, 32'h0000_0020);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h0f, 32'd3);
        rd(8'h0e, 32'd20);
        rd(8'h80, 32'h0);
        arith_scn();
        edit_scn();
        level_scn();
        end_sim();
    end
endmodule
`default_nettype wire
